// ===== rtl/jtim_defines.svh
// constants for the test-port instruction and memory access block
`ifndef JTIM_DEFINES_SVH
`define JTIM_DEFINES_SVH
`define JTIM_IR_W        5
`define JTIM_OP_IDCODE   5'h00
`define JTIM_OP_USERCODE 5'h03
`define JTIM_OP_LDADDR   5'h04
`define JTIM_OP_FETCH    5'h05
`define JTIM_OP_STORE    5'h06
`define JTIM_OP_RESTART  5'h07
`define JTIM_OP_SNAP     5'h08
`define JTIM_OP_EXT_ON   5'h09
`define JTIM_OP_EXT_OFF  5'h0A
`define JTIM_OP_NV_ON    5'h0B
`define JTIM_OP_NV_OFF   5'h0C
`define JTIM_OP_BYPASS   5'h1F
`define JTIM_IR_CAPTURE  5'h01
`define JTIM_NV_USER_LO  8'h9C
`define JTIM_BYTE_RST    8'h00
`define JTIM_UC_HI       16'h0000
`endif

// ===== rtl/jtim_pkg.sv
// types for the test-port instruction and memory access block
package jtim_pkg;
    typedef enum logic [3:0] {
        TLR    = 4'h0,
        RTI    = 4'h1,
        SEL_DR = 4'h3,
        CAP_DR = 4'h2,
        SH_DR  = 4'h6,
        EX1_DR = 4'h7,
        PAU_DR = 4'h5,
        EX2_DR = 4'h4,
        UPD_DR = 4'hC,
        SEL_IR = 4'hD,
        CAP_IR = 4'hF,
        SH_IR  = 4'hE,
        EX1_IR = 4'hA,
        PAU_IR = 4'hB,
        EX2_IR = 4'h9,
        UPD_IR = 4'h8
    } jtim_tap_t;
    typedef enum logic [2:0] {
        SEL_BYP  = 3'h0,
        SEL_ID   = 3'h1,
        SEL_UC   = 3'h3,
        SEL_ADDR = 3'h2,
        SEL_RD   = 3'h6,
        SEL_WR   = 3'h7
    } jtim_sel_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
    } jtim_mem_t;
endpackage

// ===== rtl/jtim_top.sv
// test-port instruction register, data registers and memory access
//
// Overview of operation
// - five-bit instruction: serial shift stage plus latched current instruction
// - shift-IR moves instruction stage toward tdo each rising tck
// - update-IR entry: falling tck copies shift stage to current instruction
// - all-ones is bypass, zero is identification, 03h is user code
// - 04h address load, 05h memory fetch, 06h memory store
// - 07h soft restart, 08h fault snapshot to nonvolatile memory
// - 09h extended page on, 0Ah extended page off
// - 0Bh nonvolatile page on, 0Ch nonvolatile page off
// - bypass routes tdi to tdo through one stage
// - identification word captured in capture-DR, shifted out in shift-DR
// - test-logic-reset forces identification instruction
// - identification: bit0 one, 11 maker, 16 device, 4 version bits
// - user code captured in capture-DR, shifted out in shift-DR
// - user code: zero upper half, slave address, user byte low
// - address load puts 8-bit address stage between tdi and tdo
// - memory fetch puts 8-bit read stage between tdi and tdo
// - memory store puts 8-bit write stage between tdi and tdo
// - soft restart becoming current requests a device soft_restart_cmd
// - fault snapshot becoming current requests a fault log save
// - extended page on exposes extended registers, off restores default
// - nonvolatile page on: addresses are nonvolatile, user region unreachable
// - nonvolatile page off restores default page decoding
// - tap samples tms and advances on rising tck
// - five tms-high edges reach test-logic-reset from anywhere
// - falling tck in update-DR latches the address or store shift path when it is selected
`timescale 1ns/1ps
`include "jtim_defines.svh"
module jtim_top #(
    parameter logic [10:0] MAKER_ID = 11'h155, // arbitrary value
    parameter logic [15:0] PART_ID  = 16'h5A3C, // arbitrary value
    parameter logic [3:0]  VER_ID   = 4'h6 // arbitrary value
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe,
    input  wire logic [7:0]       slave_addr,
    input  wire logic [7:0]       user_id_byte,
    input  wire logic [7:0]       mem_rd_data,
    output jtim_pkg::jtim_mem_t   mem_req,
    output logic                  mem_wr,
    output logic                  ext_page,
    output logic                  nv_page,
    output logic                  soft_restart_cmd_req,
    output logic                  save_req
);
    // tck domain reset, taken over from the system reset
    logic              trst_m_r;
    logic              trst_r;
    jtim_pkg::jtim_tap_t st_r;
    jtim_pkg::jtim_tap_t st_nxt;
    logic [4:0]        ir_sh_r;
    logic [4:0]        ir_r;
    logic [31:0]       dr_sh_r;
    logic [7:0]        addr_q_r;
    logic [7:0]        wdat_q_r;
    logic              addr_tg_r;
    logic              wr_tg_r;
    logic              boot_tg_r;
    logic              save_tg_r;
    logic              ext_q_r;
    logic              nv_q_r;
    logic              ack_m_r;
    logic              ack_r;
    logic              tdo_r;
    logic              oe_r;
    logic              rd_ack_r;
    logic [7:0]        rd_data_r;
    logic [15:0]       uc_m_r;
    logic [15:0]       uc_r;
    jtim_pkg::jtim_sel_t sel;
    logic [31:0]       id_word;
    logic [31:0]       uc_word;
    logic              shift_dr;
    logic              shift_ir;

    function automatic jtim_pkg::jtim_sel_t dec(input logic [4:0] op);
        case (op)
            `JTIM_OP_IDCODE:   dec = jtim_pkg::SEL_ID;
            `JTIM_OP_USERCODE: dec = jtim_pkg::SEL_UC;
            `JTIM_OP_LDADDR:   dec = jtim_pkg::SEL_ADDR;
            `JTIM_OP_FETCH:    dec = jtim_pkg::SEL_RD;
            `JTIM_OP_STORE:    dec = jtim_pkg::SEL_WR;
            default:           dec = jtim_pkg::SEL_BYP;
        endcase
    endfunction

    assign sel      = dec(ir_r);
    assign id_word  = {VER_ID, PART_ID, MAKER_ID, 1'b1};
    assign uc_word  = {`JTIM_UC_HI, uc_r};
    assign shift_dr = (st_r == jtim_pkg::SH_DR);
    assign shift_ir = (st_r == jtim_pkg::SH_IR);

    always_ff @(posedge tck)
    begin
        trst_m_r <= rst;
        trst_r   <= trst_m_r;
        uc_m_r   <= {slave_addr, user_id_byte};
        uc_r     <= uc_m_r;
    end

    // next tap state from tms
    always_comb
    begin
        unique case (st_r)
            jtim_pkg::TLR:    st_nxt = tms ? jtim_pkg::TLR : jtim_pkg::RTI;
            jtim_pkg::RTI:    st_nxt = tms ? jtim_pkg::SEL_DR : jtim_pkg::RTI;
            jtim_pkg::SEL_DR: st_nxt = tms ? jtim_pkg::SEL_IR : jtim_pkg::CAP_DR;
            jtim_pkg::CAP_DR: st_nxt = tms ? jtim_pkg::EX1_DR : jtim_pkg::SH_DR;
            jtim_pkg::SH_DR:  st_nxt = tms ? jtim_pkg::EX1_DR : jtim_pkg::SH_DR;
            jtim_pkg::EX1_DR: st_nxt = tms ? jtim_pkg::UPD_DR : jtim_pkg::PAU_DR;
            jtim_pkg::PAU_DR: st_nxt = tms ? jtim_pkg::EX2_DR : jtim_pkg::PAU_DR;
            jtim_pkg::EX2_DR: st_nxt = tms ? jtim_pkg::UPD_DR : jtim_pkg::SH_DR;
            jtim_pkg::UPD_DR: st_nxt = tms ? jtim_pkg::SEL_DR : jtim_pkg::RTI;
            jtim_pkg::SEL_IR: st_nxt = tms ? jtim_pkg::TLR : jtim_pkg::CAP_IR;
            jtim_pkg::CAP_IR: st_nxt = tms ? jtim_pkg::EX1_IR : jtim_pkg::SH_IR;
            jtim_pkg::SH_IR:  st_nxt = tms ? jtim_pkg::EX1_IR : jtim_pkg::SH_IR;
            jtim_pkg::EX1_IR: st_nxt = tms ? jtim_pkg::UPD_IR : jtim_pkg::PAU_IR;
            jtim_pkg::PAU_IR: st_nxt = tms ? jtim_pkg::EX2_IR : jtim_pkg::PAU_IR;
            jtim_pkg::EX2_IR: st_nxt = tms ? jtim_pkg::UPD_IR : jtim_pkg::SH_IR;
            jtim_pkg::UPD_IR: st_nxt = tms ? jtim_pkg::SEL_DR : jtim_pkg::RTI;
        endcase
    end

    always_ff @(posedge tck)
    begin
        if (trst_r)
            st_r <= jtim_pkg::TLR;
        else
            st_r <= st_nxt;
    end

    // instruction shift stage
    always_ff @(posedge tck)
    begin
        if (trst_r)
            ir_sh_r <= `JTIM_IR_CAPTURE;
        else if (st_r == jtim_pkg::CAP_IR)
            ir_sh_r <= `JTIM_IR_CAPTURE;
        else if (shift_ir)
            ir_sh_r <= {tdi, ir_sh_r[4:1]};
    end

    // data shift path; length follows the selection
    always_ff @(posedge tck)
    begin
        if (trst_r)
            dr_sh_r <= '0;
        else if (st_r == jtim_pkg::CAP_DR)
        begin
            unique case (sel)
                jtim_pkg::SEL_ID:   dr_sh_r <= id_word;
                jtim_pkg::SEL_UC:   dr_sh_r <= uc_word;
                jtim_pkg::SEL_ADDR: dr_sh_r <= {24'h00_0000, addr_q_r};
                jtim_pkg::SEL_WR:   dr_sh_r <= {24'h00_0000, wdat_q_r};
                // the old shift path contents are kept until the system side answers
                jtim_pkg::SEL_RD:
                    if (ack_r == addr_tg_r)
                        dr_sh_r <= {24'h00_0000, rd_data_r};
                jtim_pkg::SEL_BYP:  dr_sh_r <= '0;
            endcase
        end
        else if (shift_dr)
        begin
            unique case (sel)
                jtim_pkg::SEL_ID, jtim_pkg::SEL_UC:
                    dr_sh_r <= {tdi, dr_sh_r[31:1]};
                jtim_pkg::SEL_ADDR, jtim_pkg::SEL_RD, jtim_pkg::SEL_WR:
                    dr_sh_r <= {24'h00_0000, tdi, dr_sh_r[7:1]};
                jtim_pkg::SEL_BYP:
                    dr_sh_r <= {31'h0000_0000, tdi};
            endcase
        end
    end

    // read answer crosses back as a toggle level
    always_ff @(posedge tck)
    begin
        ack_m_r <= rd_ack_r;
        ack_r   <= ack_m_r;
    end

    // falling tck updates keep parallel outputs clean of shifting
    always_ff @(negedge tck)
    begin
        if (trst_r || st_r == jtim_pkg::TLR)
            ir_r <= `JTIM_OP_IDCODE;
        else if (st_r == jtim_pkg::UPD_IR)
            ir_r <= ir_sh_r;
    end

    always_ff @(negedge tck)
    begin
        if (trst_r)
        begin
            boot_tg_r <= 1'b0;
            save_tg_r <= 1'b0;
            ext_q_r   <= 1'b0;
            nv_q_r    <= 1'b0;
        end
        else if (st_r == jtim_pkg::UPD_IR)
        begin
            if (ir_sh_r == `JTIM_OP_RESTART)
                boot_tg_r <= ~boot_tg_r;
            if (ir_sh_r == `JTIM_OP_SNAP)
                save_tg_r <= ~save_tg_r;
            if (ir_sh_r == `JTIM_OP_EXT_ON)
                ext_q_r <= 1'b1;
            if (ir_sh_r == `JTIM_OP_EXT_OFF)
                ext_q_r <= 1'b0;
            if (ir_sh_r == `JTIM_OP_NV_ON)
                nv_q_r <= 1'b1;
            if (ir_sh_r == `JTIM_OP_NV_OFF)
                nv_q_r <= 1'b0;
        end
    end

    always_ff @(negedge tck)
    begin
        if (trst_r)
        begin
            addr_q_r  <= `JTIM_BYTE_RST;
            wdat_q_r  <= `JTIM_BYTE_RST;
            addr_tg_r <= 1'b0;
            wr_tg_r   <= 1'b0;
        end
        else if (st_r == jtim_pkg::UPD_DR && sel == jtim_pkg::SEL_ADDR)
        begin
            addr_q_r  <= dr_sh_r[7:0];
            addr_tg_r <= ~addr_tg_r;
        end
        else if (st_r == jtim_pkg::UPD_DR && sel == jtim_pkg::SEL_WR)
        begin
            wdat_q_r <= dr_sh_r[7:0];
            wr_tg_r  <= ~wr_tg_r;
        end
    end

    // tdo changes on falling tck, driven only while shifting
    always_ff @(negedge tck)
    begin
        if (trst_r)
        begin
            tdo_r <= 1'b0;
            oe_r  <= 1'b0;
        end
        else
        begin
            tdo_r <= shift_ir ? ir_sh_r[0] : dr_sh_r[0];
            oe_r  <= shift_ir || shift_dr;
        end
    end

    assign tdo    = tdo_r;
    assign tdo_oe = oe_r;

    // system clock side; toggles and levels pass two flops first
    logic [2:0] a_s_r;
    logic [2:0] w_s_r;
    logic [2:0] b_s_r;
    logic [2:0] s_s_r;
    logic [1:0] e_s_r;
    logic [1:0] n_s_r;
    logic       rd_pend_r;
    jtim_pkg::jtim_mem_t req_r;
    logic       wr_r;
    logic       boot_r;
    logic       save_r;
    logic       a_edge;
    logic       w_edge;
    logic       user_blk;

    // words change with each toggle and then stay stable for many tck periods after it
    assign a_edge   = a_s_r[1] ^ a_s_r[2];
    assign w_edge   = w_s_r[1] ^ w_s_r[2];
    assign user_blk = n_s_r[1] && (req_r.addr >= `JTIM_NV_USER_LO);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            a_s_r <= '0;
            w_s_r <= '0;
            b_s_r <= '0;
            s_s_r <= '0;
            e_s_r <= '0;
            n_s_r <= '0;
        end
        else
        begin
            a_s_r <= {a_s_r[1:0], addr_tg_r};
            w_s_r <= {w_s_r[1:0], wr_tg_r};
            b_s_r <= {b_s_r[1:0], boot_tg_r};
            s_s_r <= {s_s_r[1:0], save_tg_r};
            e_s_r <= {e_s_r[0], ext_q_r};
            n_s_r <= {n_s_r[0], nv_q_r};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            req_r     <= '0;
            wr_r      <= 1'b0;
            rd_pend_r <= 1'b0;
            rd_ack_r  <= 1'b0;
            rd_data_r <= `JTIM_BYTE_RST;
            boot_r    <= 1'b0;
            save_r    <= 1'b0;
        end
        else
        begin
            wr_r <= w_edge && !user_blk;
            boot_r <= b_s_r[1] ^ b_s_r[2];
            save_r <= s_s_r[1] ^ s_s_r[2];
            if (a_edge)
                req_r.addr <= addr_q_r;
            if (w_edge)
                req_r.wdata <= wdat_q_r;
            rd_pend_r <= a_edge;
            if (rd_pend_r)
            begin
                rd_data_r <= user_blk ? `JTIM_BYTE_RST : mem_rd_data;
                rd_ack_r  <= a_s_r[2];
            end
        end
    end

    assign mem_req    = req_r;
    assign mem_wr     = wr_r;
    assign ext_page   = e_s_r[1];
    assign nv_page    = n_s_r[1];
    assign soft_restart_cmd_req = boot_r;
    assign save_req   = save_r;
    sequence s_ir_load;
        st_r == jtim_pkg::CAP_IR ##1 st_r == jtim_pkg::SH_IR;
    endsequence
    property p_ir_shift;
        @(posedge tck) disable iff (trst_r)
        shift_ir |=> ir_sh_r == {$past(tdi), $past(ir_sh_r[4:1])};
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("ir shift wrong");
    property p_ir_cap;
        @(posedge tck) disable iff (trst_r)
        s_ir_load |-> ir_sh_r == `JTIM_IR_CAPTURE;
    endproperty
    a_ir_cap: assert property (p_ir_cap) else $error("ir capture wrong");
    property p_ir_upd;
        @(posedge tck) disable iff (trst_r)
        st_r == jtim_pkg::UPD_IR |=> ir_r == $past(ir_sh_r);
    endproperty
    a_ir_upd: assert property (p_ir_upd) else $error("ir update wrong");
    property p_tlr_id;
        @(posedge tck) disable iff (trst_r)
        st_r == jtim_pkg::TLR |=> ir_r == `JTIM_OP_IDCODE;
    endproperty
    a_tlr_id: assert property (p_tlr_id) else $error("reset not idcode");
    property p_five_tms;
        @(posedge tck) disable iff (trst_r)
        tms [*5] |=> st_r == jtim_pkg::TLR;
    endproperty
    a_five_tms: assert property (p_five_tms) else $error("tms reset failed");
    property p_id_cap;
        @(posedge tck) disable iff (trst_r)
        st_r == jtim_pkg::CAP_DR && sel == jtim_pkg::SEL_ID |=> dr_sh_r == id_word && dr_sh_r[0];
    endproperty
    a_id_cap: assert property (p_id_cap) else $error("idcode capture wrong");
    property p_uc_cap;
        @(posedge tck) disable iff (trst_r)
        st_r == jtim_pkg::CAP_DR && sel == jtim_pkg::SEL_UC |=> dr_sh_r[31:16] == 16'h0000;
    endproperty
    a_uc_cap: assert property (p_uc_cap) else $error("usercode capture wrong");
    property p_byp;
        @(posedge tck) disable iff (trst_r)
        shift_dr && sel == jtim_pkg::SEL_BYP |=> dr_sh_r[0] == $past(tdi);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass wrong");
    property p_wr_pulse;
        @(posedge ref_clk) disable iff (rst)
        mem_wr |-> !(nv_page && mem_req.addr >= `JTIM_NV_USER_LO) ##1 !mem_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("bad write strobe");
    property p_boot;
        @(posedge ref_clk) disable iff (rst)
        $changed(b_s_r[2]) |-> soft_restart_cmd_req;
    endproperty
    a_boot: assert property (p_boot) else $error("soft_restart_cmd not raised");
endmodule // jtim_top

// ===== verification/jtim_host.sv
// host-side test controller model that drives the serial test port
`timescale 1ns/1ps
module jtim_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // tck stands low between frames; this model is the only port master
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one 80 ns link cycle: change after the falling edge, sample tdo before the rise
    task automatic tick(input logic m, input logic dv, output logic q);
        tms = m;
        tdi = dv;
        #40;
        q = tdo;
        tck = 1'b1;
        #40;
        tck = 1'b0;
    endtask

    // idle tdi shows the inverse of its last value, never a stale copy
    task automatic move(input int n, input logic m);
        logic q;
        repeat (n) tick(m, ~tdi, q);
    endtask

    // one scan from run-test/idle back to run-test/idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, ~tdi, q);
        if (ir)
            tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
        tick(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, ~tdi, q);
        tick(1'b0, ~tdi, q);
    endtask
endmodule // jtim_host

// ===== verification/jtim_top_bench.sv
// self-checking bench for the test-port instruction and memory block
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module jtim_top_bench;
    // arbitrary identification values
    localparam logic [31:0] ID_WORD = {4'h3, 16'h1234, 11'h2A5, 1'h1};

    logic                ref_clk      = 1'b0;
    logic                rst          = 1'b1;
    logic [7:0]          slave_addr   = 8'h00;
    logic [7:0]          user_id_byte = 8'h00;
    wire  [7:0]          mem_rd_data;
    wire                 tck;
    wire                 tms;
    wire                 tdi;
    logic                tdo;
    logic                tdo_oe;
    logic                mem_wr;
    logic                ext_page;
    logic                nv_page;
    logic                soft_restart_cmd_req;
    logic                save_req;
    jtim_pkg::jtim_mem_t mem_req;
    logic [7:0]          mem [256];
    logic [31:0]         d;
    int                  fails        = 0;
    int                  cmp_count    = 0;
    int                  rb_n         = 0;
    int                  sv_n         = 0;

    // rows: opcode, ext page, nv page, reboots so far, saves so far
    typedef struct packed {logic [4:0] op; logic ext; logic nv; logic rb; logic sv;} jtim_row_t;
    jtim_row_t rows [8] = '{9'h1F0, 9'h072, 9'h083, 9'h09B, 9'h0A3, 9'h0B7, 9'h0C3, 9'h153};

    always #5 ref_clk = ~ref_clk;

    jtim_host i_jtim_host (
        .tck (tck),
        .tms (tms),
        .tdi (tdi),
        .tdo (tdo)
    );

    jtim_top #(
        .MAKER_ID (11'h2A5),
        .PART_ID  (16'h1234),
        .VER_ID   (4'h3)
    ) i_jtim_top (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .tck          (tck),
        .tms          (tms),
        .tdi          (tdi),
        .tdo          (tdo),
        .tdo_oe       (tdo_oe),
        .slave_addr   (slave_addr),
        .user_id_byte (user_id_byte),
        .mem_rd_data  (mem_rd_data),
        .mem_req      (mem_req),
        .mem_wr       (mem_wr),
        .ext_page     (ext_page),
        .nv_page      (nv_page),
        .soft_restart_cmd_req   (soft_restart_cmd_req),
        .save_req     (save_req)
    );

    // memory reads through at once, so the byte stands when the design samples it
    assign mem_rd_data = mem[mem_req.addr];

    // writes land on the strobe; pulses are counted
    always @(posedge ref_clk)
    begin
        if (mem_wr === 1'b1)
            mem[mem_req.addr] <= mem_req.wdata;
        if (soft_restart_cmd_req === 1'b1)
            rb_n <= rb_n + 1;
        if (save_req === 1'b1)
            sv_n <= sv_n + 1;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic op_dr(input logic [4:0] op, input int n, input logic [31:0] din);
        logic [31:0] q;
        i_jtim_host.scan(1'b1, 5, {27'h0, op}, q);
        i_jtim_host.scan(1'b0, n, din, d);
    endtask

    initial
    begin
        #600_000;
        fails++;
        complete_run();
    end

    initial
    begin
        foreach (mem[i])
            mem[i] = 8'(i) ^ 8'hC3;
        // reset spans four tck edges, more than three ref_clk cycles
        i_jtim_host.move(4, 1'b1);
        `CHK({tdo_oe, ext_page, nv_page, mem_wr, soft_restart_cmd_req, save_req}, 6'h00)
        @(posedge ref_clk);
        rst <= 1'b0;
        slave_addr <= 8'hA5;
        user_id_byte <= 8'h3C;
        // offset keeps tck edges off the ref_clk edges
        #3;
        i_jtim_host.move(3, 1'b1);
        i_jtim_host.move(1, 1'b0);
        i_jtim_host.scan(1'b0, 32, 32'h0000_0000, d);
        `CHK(d, ID_WORD)

        foreach (rows[k])
        begin
            i_jtim_host.scan(1'b1, 5, {27'h0, rows[k].op}, d);
            `CHK(d[4:0], 5'h01)
            i_jtim_host.move(2, 1'b0);
            i_jtim_host.scan(1'b0, 8, 32'h0000_00B4, d);
            `CHK(d[7:1], 7'h34)
            `CHK(ext_page, rows[k].ext)
            `CHK(nv_page, rows[k].nv)
            `CHK(rb_n, int'(rows[k].rb))
            `CHK(sv_n, int'(rows[k].sv))
        end

        op_dr(5'h03, 32, 32'h0000_0000);
        `CHK(d, 32'h0000_A53C)

        // store then fetch back through a fresh address load
        op_dr(5'h04, 8, 32'h0000_0012);
        op_dr(5'h06, 8, 32'h0000_005A);
        i_jtim_host.move(2, 1'b0);
        `CHK(mem[8'h12], 8'h5A)
        `CHK(mem_req.addr, 8'h12)
        op_dr(5'h04, 8, 32'h0000_0012);
        `CHK(d[7:0], 8'h12)
        op_dr(5'h05, 8, 32'h0000_0000);
        `CHK(d[7:0], 8'h5A)

        // user nonvolatile region stays out of reach
        i_jtim_host.scan(1'b1, 5, 32'h0000_000B, d);
        i_jtim_host.move(2, 1'b0);
        `CHK(nv_page, 1'b1)
        op_dr(5'h04, 8, 32'h0000_009C);
        op_dr(5'h06, 8, 32'h0000_0077);
        i_jtim_host.move(2, 1'b0);
        `CHK(mem[8'h9C], 8'h5F)
        op_dr(5'h04, 8, 32'h0000_009C);
        op_dr(5'h05, 8, 32'h0000_0000);
        `CHK(d[7:0], 8'h00)
        i_jtim_host.scan(1'b1, 5, 32'h0000_000C, d);
        i_jtim_host.move(2, 1'b0);
        `CHK(nv_page, 1'b0)
        op_dr(5'h04, 8, 32'h0000_0012);
        op_dr(5'h05, 8, 32'h0000_0000);
        `CHK(d[7:0], 8'h5A)
        `CHK(tdo_oe, 1'b0)

        // five high tms edges from a bypass instruction restore identification
        i_jtim_host.scan(1'b1, 5, 32'h0000_001F, d);
        i_jtim_host.move(5, 1'b1);
        i_jtim_host.move(1, 1'b0);
        i_jtim_host.scan(1'b0, 32, 32'h0000_0000, d);
        `CHK(d, ID_WORD)
        complete_run();
    end
endmodule // jtim_top_bench
